/* hw/rwdt_pkg.sv */
// Constants shared by the runaway watchdog timer.
// Assumes byte offsets relative to the block's base address.
package rwdt_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [31:0] RWDT_BASE_ADDR  = 32'h4004_0000;
  localparam logic [15:0] RWDT_MODE_OFS   = 16'h0000;
  localparam logic [15:0] RWDT_CMD_OFS    = 16'h0004;
  localparam logic [15:0] RWDT_STATUS_OFS = 16'h0008;
  localparam logic [15:0] RWDT_MASK_OFS   = 16'h000C;

  // ----------------------------------------------------------------
  // Mode register fields
  // ----------------------------------------------------------------
  localparam int RWDT_ENABLE_BIT = 7;
  localparam int RWDT_SEL_LSB    = 4;
  localparam int RWDT_SEL_MSB    = 6;
  localparam int RWDT_IDLE_BIT   = 2;
  localparam int RWDT_ACTION_BIT = 1;
  localparam int RWDT_SPARE_BIT  = 0;

  localparam logic       RWDT_ENABLE_RST = 1'h1;
  localparam logic [2:0] RWDT_SEL_RST    = 3'h0;
  localparam logic       RWDT_IDLE_RST   = 1'h0;
  localparam logic       RWDT_ACTION_RST = 1'h1;
  localparam logic       RWDT_SPARE_RST  = 1'h0;
  localparam logic [2:0] RWDT_SEL_MAX    = 3'h5;

  // ----------------------------------------------------------------
  // Command codes and counter
  // ----------------------------------------------------------------
  localparam logic [7:0] RWDT_CODE_CLEAR   = 8'h4E;
  localparam logic [7:0] RWDT_CODE_DISABLE = 8'hB1;

  localparam int RWDT_CNT_W      = 25;
  localparam int RWDT_BASE_LOG2  = 15;
  localparam int RWDT_STEP_LOG2  = 2;

endpackage : rwdt_pkg

/* hw/rwdt_top.sv */
// Runaway watchdog timer with mode, command, status and mask registers.
// Assumes a single clock, synchronous inputs and a plain register port.
//
// What this block does
// - On timeout raise the timeout interrupt or a reset, per action select.
// - The timeout interrupt is a non-maskable source to the processor.
// - On timeout the active-low timeout pin signal is driven low.
// - That pin is not brought out of this product.
// - Mode register at offset 0x0, command register at 0x4, base 0x4004_0000.
// - Counter selects timeout after 2^15..2^25 cycles; codes 110, 111 barred.
// - Writing 0x4E clears the counter; 0xB1 disables; other codes reserved.
// - Action select: 0 interrupt, 1 reset; resets to 1.
// - Counting starts right after reset release without software.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps

module rwdt_top
  import rwdt_pkg::*;
#(
  parameter int TIMEOUT_BASE_LOG2 = RWDT_BASE_LOG2
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        clk_en,
  input  wire logic        idle_mode,
  input  wire logic [15:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             timeout_interrupt,
  output logic             reset_request,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  logic                  enable;
  logic [2:0]            sel;
  logic                  idle_run;
  logic                  action_select;
  logic                  spare;
  logic                  status;
  logic                  mask;
  logic [RWDT_CNT_W-1:0] count;
  logic [RWDT_CNT_W-1:0] terminal;
  logic                  timeout_output_pin_n;
  logic                  running;
  logic                  tmo_event;
  logic                  wr_mode;
  logic                  wr_cmd;
  logic                  wr_status;
  logic                  wr_mask;
  logic                  cmd_clear;
  logic                  cmd_disable;
  logic [4:0]            shift;

  assign wr_mode   = reg_wr && (reg_addr == RWDT_MODE_OFS);
  assign wr_cmd    = reg_wr && (reg_addr == RWDT_CMD_OFS);
  assign wr_status = reg_wr && (reg_addr == RWDT_STATUS_OFS);
  assign wr_mask   = reg_wr && (reg_addr == RWDT_MASK_OFS);

  assign cmd_clear   = wr_cmd && (reg_wdata[7:0] == RWDT_CODE_CLEAR);
  assign cmd_disable = wr_cmd && (reg_wdata[7:0] == RWDT_CODE_DISABLE);

  // ----------------------------------------------------------------
  // Mode register
  // ----------------------------------------------------------------
  // action reset value
  always_ff @(posedge clk) begin
    if (srst) begin
      enable        <= RWDT_ENABLE_RST;
      sel           <= RWDT_SEL_RST;
      idle_run      <= RWDT_IDLE_RST;
      action_select <= RWDT_ACTION_RST;
      spare         <= RWDT_SPARE_RST;
    end else if (clk_en) begin
      if (wr_mode) begin
        enable        <= reg_wdata[RWDT_ENABLE_BIT];
        idle_run      <= reg_wdata[RWDT_IDLE_BIT];
        action_select <= reg_wdata[RWDT_ACTION_BIT];
        spare         <= reg_wdata[RWDT_SPARE_BIT];
        if (reg_wdata[RWDT_SEL_MSB:RWDT_SEL_LSB] <= RWDT_SEL_MAX) begin
          sel <= reg_wdata[RWDT_SEL_MSB:RWDT_SEL_LSB];
        end
      end else if (cmd_disable) begin
        enable <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Binary counter
  // ----------------------------------------------------------------
  // Counting pauses in idle unless software asked it to keep running.
  assign running = enable && (!idle_mode || idle_run);

  assign shift    = 5'(TIMEOUT_BASE_LOG2)
                  + 5'(RWDT_STEP_LOG2) * {2'b00, sel};
  assign terminal = RWDT_CNT_W'((26'h1 << shift) - 26'h1);

  assign tmo_event = running && (count == terminal);

  always_ff @(posedge clk) begin
    if (srst) begin
      count <= '0;
    end else if (clk_en) begin
      if (!enable || cmd_clear || cmd_disable || tmo_event) begin
        count <= '0;
      end else if (running) begin
        count <= count + RWDT_CNT_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Timeout consequences
  // ----------------------------------------------------------------
  // nmi or reset
  always_ff @(posedge clk) begin
    if (srst) begin
      timeout_interrupt <= 1'b0;
    end else if (clk_en) begin
      timeout_interrupt <= tmo_event && !action_select;
    end
  end

  // The reset request stays up until the system reset comes back to us.
  always_ff @(posedge clk) begin
    if (srst) begin
      reset_request <= 1'b0;
    end else if (clk_en && tmo_event && action_select) begin
      reset_request <= 1'b1;
    end
  end

  // internal pin
  // The low level is kept on chip and only visible in the status read.
  always_ff @(posedge clk) begin
    if (srst) begin
      timeout_output_pin_n <= 1'b1;
    end else if (clk_en) begin
      if (tmo_event) begin
        timeout_output_pin_n <= 1'b0;
      end else if (cmd_clear || !enable) begin
        timeout_output_pin_n <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status, mask and interrupt
  // ----------------------------------------------------------------
  // A timeout in the same cycle as a write-one-to-clear keeps the bit set.
  always_ff @(posedge clk) begin
    if (srst) begin
      status <= 1'b0;
    end else if (clk_en) begin
      status <= (status && !(wr_status && reg_wdata[0])) || tmo_event;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mask <= 1'b0;
    end else if (clk_en && wr_mask) begin
      mask <= reg_wdata[0];
    end
  end

  assign irq = status && mask;

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // read mux
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= '0;
    end else if (clk_en) begin
      reg_rdata <= '0;
      if (reg_rd) begin
        unique case (reg_addr)
          RWDT_MODE_OFS:   reg_rdata <= {24'h00_0000, enable, sel, 1'b0,
                                         idle_run, action_select, spare};
          RWDT_STATUS_OFS: reg_rdata <= {30'h0000_0000,
                                         !timeout_output_pin_n, status};
          RWDT_MASK_OFS:   reg_rdata <= {31'h0000_0000, mask};
          default:         reg_rdata <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_start_reset;
    @(posedge clk) disable iff (srst)
      $past(srst) |-> (enable && action_select && count == '0);
  endproperty
  a_start_reset: assert property (p_start_reset)
    else $error("mode not at reset values after reset");

  property p_hold_zero;
    @(posedge clk) disable iff (srst)
      (clk_en && !enable) |=> (count == '0);
  endproperty
  a_hold_zero: assert property (p_hold_zero)
    else $error("counter moved while disabled");

  property p_clear;
    @(posedge clk) disable iff (srst)
      (clk_en && cmd_clear) |=> (count == '0);
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear code did not zero the counter");

  property p_disable;
    @(posedge clk) disable iff (srst)
      (clk_en && cmd_disable) |=> !enable ##1 (count == '0);
  endproperty
  a_disable: assert property (p_disable)
    else $error("disable code did not stop the watchdog");

  property p_nmi;
    @(posedge clk) disable iff (srst)
      (clk_en && tmo_event && !action_select)
        |=> timeout_interrupt && !reset_request;
  endproperty
  a_nmi: assert property (p_nmi)
    else $error("timeout did not raise the interrupt");

  property p_reset;
    @(posedge clk) disable iff (srst)
      (clk_en && tmo_event && action_select)
        |=> reset_request && !timeout_interrupt;
  endproperty
  a_reset: assert property (p_reset)
    else $error("timeout did not request a reset");

  property p_pin_low;
    @(posedge clk) disable iff (srst)
      (clk_en && tmo_event) |=> !timeout_output_pin_n && status;
  endproperty
  a_pin_low: assert property (p_pin_low)
    else $error("timeout did not pull the pin low");

  property p_barred_sel;
    @(posedge clk) disable iff (srst)
      (clk_en && wr_mode
        && reg_wdata[RWDT_SEL_MSB:RWDT_SEL_LSB] > RWDT_SEL_MAX)
        |=> $stable(sel);
  endproperty
  a_barred_sel: assert property (p_barred_sel)
    else $error("barred detection code was stored");

  property p_event_at_term;
    @(posedge clk) disable iff (srst)
      (clk_en && running && count == terminal - RWDT_CNT_W'(1)
        && !cmd_clear && !wr_mode && !cmd_disable)
        |=> (count == terminal) && (tmo_event || !running);
  endproperty
  a_event_at_term: assert property (p_event_at_term)
    else $error("timeout missed its terminal count");

  // A paused counter must not creep towards a timeout while the CPU idles.
  property p_pause;
    @(posedge clk) disable iff (srst)
      (clk_en && enable && idle_mode && !idle_run && !cmd_clear
        && !cmd_disable) |=> $stable(count);
  endproperty
  a_pause: assert property (p_pause)
    else $error("counter moved while paused in idle");

  property p_rdata_idle;
    @(posedge clk) disable iff (srst)
      (clk_en && !reg_rd) |=> (reg_rdata == '0);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data stood outside its read cycle");

  property p_reset_holds;
    @(posedge clk) disable iff (srst)
      reset_request |=> reset_request;
  endproperty
  a_reset_holds: assert property (p_reset_holds)
    else $error("reset request dropped before the system reset");

  c_nmi:   cover property (@(posedge clk) disable iff (srst)
                           timeout_interrupt);
  c_reset: cover property (@(posedge clk) disable iff (srst)
                           $rose(reset_request));
  c_clear: cover property (@(posedge clk) disable iff (srst)
                           cmd_clear && count != '0);
  c_pause: cover property (@(posedge clk) disable iff (srst)
                           enable && idle_mode && !idle_run);
  c_off:   cover property (@(posedge clk) disable iff (srst)
                           cmd_disable);

endmodule : rwdt_top

/* tb/runaway_watchdog_timer_tb.sv */
// Self-checking bench for the runaway watchdog timer.
// Assumes the short timeout base of 2^4 cycles and a 100 MHz clock.
`timescale 1ns/1ps

module runaway_watchdog_timer_tb;
  import rwdt_pkg::*;
  localparam int BL = 4;
  logic        clk = 0, tb_rst = 1, clk_en = 1, idle_mode = 0;
  logic        reg_wr = 0, reg_rd = 0, chip_rst, irq;
  logic        timeout_interrupt, reset_request, srst;
  logic [15:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, d;
  logic [7:0]  nmi_count, c0;
  int          miscompares = 0, checks_done = 0, seed = 32'h24ed, n;

  always #5 clk = ~clk;
  assign srst = tb_rst | chip_rst;

  rwdt_top #(.TIMEOUT_BASE_LOG2(BL)) dut (.clk(clk), .srst(srst),
    .clk_en(clk_en), .idle_mode(idle_mode), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .timeout_interrupt(timeout_interrupt),
    .reset_request(reset_request), .irq(irq));
  rwdt_cpu_model cpu (.clk(clk), .timeout_interrupt(timeout_interrupt),
    .reset_request(reset_request), .nmi_count(nmi_count),
    .chip_rst(chip_rst));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    if (miscompares == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Timeout counts must match exactly: the bus adds no hidden latency.
  function automatic logic [31:0] in_win(input int a, input int e);
    return {31'h0, a == e};
  endfunction

  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // Bounded wait for a timeout consequence; cycles are returned in n.
  task automatic wait_out(input bit use_rst, output int cnt);
    cnt = 0;
    while ((use_rst ? reset_request : timeout_interrupt) !== 1'b1) begin
      @(posedge clk);
      #1 cnt++;
      if (cnt > 40000) begin
        miscompares++;
        $display("BAD %0t no timeout consequence seen", $time);
        test_done();
      end
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    tb_rst <= 1'b0;
    wait_out(1, n);
    chk(in_win(n, 1 << BL), 1);
    repeat (3) @(posedge clk);
    #1 chk({31'h0, reset_request}, 0);
    rd(RWDT_MODE_OFS, d);
    chk(d, 32'h0000_0082);
    wr(RWDT_MODE_OFS, 32'h0000_0080);
    rd(RWDT_CMD_OFS, d);
    chk(d, 32'h0000_0000);
    rd(16'h0010, d);
    chk(d, 32'h0000_0000);
    wr(RWDT_MASK_OFS, 32'h0000_0001);
    wr(RWDT_CMD_OFS, {24'h0, RWDT_CODE_CLEAR});
    wait_out(0, n);
    chk(in_win(n, 1 << BL), 1);
    chk({30'h0, reset_request, irq}, 1);
    @(posedge clk);
    #1 chk({31'h0, timeout_interrupt}, 0);
    rd(RWDT_STATUS_OFS, d);
    chk(d, 32'h0000_0003);
    wr(RWDT_CMD_OFS, {24'h0, RWDT_CODE_CLEAR});
    wr(RWDT_STATUS_OFS, 32'h0000_0001);
    rd(RWDT_STATUS_OFS, d);
    chk({d[1:0], irq}, 0);
    wr(RWDT_MASK_OFS, 32'h0000_0000);
    c0 = nmi_count;
    wait_out(0, n);
    chk({31'h0, irq}, 0);
    @(posedge clk);
    #1 chk(nmi_count, c0 + 8'h01);
    c0 = nmi_count;
    for (int i = 0; i < 20; i++) begin
      wr(RWDT_CMD_OFS, {24'h0, RWDT_CODE_CLEAR});
      repeat (3 + ($unsigned($random(seed)) % 10)) @(posedge clk);
    end
    chk(nmi_count, c0);
    d = {24'h0, RWDT_CODE_CLEAR};
    while (d[7:0] == RWDT_CODE_CLEAR || d[7:0] == RWDT_CODE_DISABLE) begin
      d = {24'h0, 8'($random(seed))};
    end
    wr(RWDT_CMD_OFS, {24'h0, RWDT_CODE_CLEAR});
    wr(RWDT_CMD_OFS, d);
    wait_out(0, n);
    chk(in_win(n + 2, 1 << BL), 1);
    wr(RWDT_CMD_OFS, {24'h0, RWDT_CODE_DISABLE});
    rd(RWDT_MODE_OFS, d);
    chk(d, 32'h0000_0000);
    c0 = nmi_count;
    repeat (100) @(posedge clk);
    chk(nmi_count, c0);
    wr(RWDT_MODE_OFS, 32'h0000_0080);
    wait_out(0, n);
    chk(in_win(n, 1 << BL), 1);
    for (int s = 0; s < 6; s++) begin
      wr(RWDT_MODE_OFS, 32'h0000_0080 | (s << RWDT_SEL_LSB));
      wr(RWDT_CMD_OFS, {24'h0, RWDT_CODE_CLEAR});
      wait_out(0, n);
      chk(in_win(n, 1 << (BL + 2 * s)), 1);
    end
    wr(RWDT_MODE_OFS, 32'h0000_00E0);
    rd(RWDT_MODE_OFS, d);
    chk(d, 32'h0000_00D0);
    @(posedge clk);
    idle_mode <= 1'b1;
    wr(RWDT_MODE_OFS, 32'h0000_0080);
    wr(RWDT_CMD_OFS, {24'h0, RWDT_CODE_CLEAR});
    c0 = nmi_count;
    repeat (40) @(posedge clk);
    chk(nmi_count, c0);
    idle_mode <= 1'b0;
    wait_out(0, n);
    chk(in_win(n, 1 << BL), 1);
    wr(RWDT_MODE_OFS, 32'h0000_0084);
    idle_mode <= 1'b1;
    wr(RWDT_CMD_OFS, {24'h0, RWDT_CODE_CLEAR});
    wait_out(0, n);
    chk(in_win(n, 1 << BL), 1);
    wr(RWDT_CMD_OFS, {24'h0, RWDT_CODE_CLEAR});
    @(posedge clk);
    clk_en <= 1'b0;
    c0 = nmi_count;
    repeat (30) @(posedge clk);
    clk_en <= 1'b1;
    chk(nmi_count, c0);
    wait_out(0, n);
    chk(in_win(n + 1, 1 << BL), 1);
    test_done();
  end
endmodule // runaway_watchdog_timer_tb

/* tb/rwdt_cpu_model.sv */
// Behavioural model of the processor side: NMI intake and chip reset logic.
// Assumes one clock; chip_rst is fed back by the bench into the block reset.
`timescale 1ns/1ps

module rwdt_cpu_model (
  input  wire logic       clk,
  input  wire logic       timeout_interrupt,
  input  wire logic       reset_request,
  output logic      [7:0] nmi_count,
  output logic            chip_rst
);
  // ----------------------------------------------------------------
  // Interrupt intake
  // ----------------------------------------------------------------
  initial nmi_count = 8'h00;
  // non-maskable intake: no mask can refuse it, so every pulse counts.
  always @(posedge clk) begin
    if (timeout_interrupt === 1'b1) begin
      nmi_count <= nmi_count + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Reset logic
  // ----------------------------------------------------------------
  initial chip_rst = 1'b0;
  // reset action: a request resets the chip one cycle later.
  always @(posedge clk) begin
    chip_rst <= (reset_request === 1'b1);
  end
endmodule // rwdt_cpu_model
